// >>> inc/ssl_map.svh
// Offsets, field positions, reset values and timing counts of the smoothing filter
`ifndef SSL_MAP_SVH
`define SSL_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define SSL_CTRL_OFFS      12'h000
`define SSL_TICK_OFFS      12'h004
`define SSL_STAT_OFFS      12'h008
`define SSL_CHAN_BASE      12'h100
`define SSL_CHAN_STRIDE    12'h010
`define SSL_CH_ENA_OFFS    4'h0
`define SSL_CH_RAW_OFFS    4'h4
`define SSL_CH_TG_OFFS     4'h8
`define SSL_CH_OUT_OFFS    4'hC

// ****************************************
// Field positions, reset values and output limits
// ****************************************
`define SSL_CTRL_RUN_BIT   0
`define SSL_TICK_RST       16'h0001
`define SSL_GAIN_ONE       16'h0064
`define SSL_OUT_MAX        32'sh0000_7FFF
`define SSL_OUT_MIN        -32'sh0000_8000

// ****************************************
// Timing counts
// ****************************************
`define SSL_CLK_MHZ        40
`define SSL_BASE_TICK_US   10000
`define SSL_BASE_TICK_CYC  (`SSL_CLK_MHZ * `SSL_BASE_TICK_US)
`define SSL_FAST_TG_MAX    16'h000A

`endif

// >>> inc/ssl_pkg.sv
// Types shared by the smoothing filter files
package ssl_pkg;
  typedef enum logic [1:0] {
    SSL_IDLE,
    SSL_FIRST,
    SSL_RUN
  } ssl_state_t;
  typedef logic signed [15:0] ssl_sample_t;
endpackage

// >>> testbench/ssl_axi_master.sv
// Register bus master standing in for the configuring controller
`timescale 1ns/1ps

module ssl_axi_master (
  // Clock
  input  wire logic        sys_clk_i,
  // Write side
  output logic [11:0]      s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // Read side
  output logic [11:0]      s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // Idle bus at time zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
  end

  // One write; released lines show the inverse value
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge sys_clk_i);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    forever begin
      @(posedge sys_clk_i);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'h0;
        s_axi_awaddr  <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'h0;
        s_axi_wdata  <= ~d;
      end
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        break;
      end
    end
  endtask

  // One read
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge sys_clk_i);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    forever begin
      @(posedge sys_clk_i);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'h0;
        s_axi_araddr  <= ~a;
      end
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        break;
      end
    end
  endtask
endmodule

// >>> testbench/ssl_top_properties.sv
// Port checks on the smoothing filter top: bus answers and tick spacing
`timescale 1ns/1ps

module ssl_top_props #(
  parameter int unsigned N_CHAN   = 32,
  parameter int unsigned TICK_CYC = 4
) (
  // Clock and reset
  input wire logic        sys_clk_i,
  input wire logic        reset_n_i,
  // Write side
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Read side
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Program cycle marker
  input wire logic        cycle_tick_o
);
  // One clock domain, reset disables all checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // Write answer timing and holding
  b_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer missing");
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  b_release_a: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer stuck");
  // Read answer timing and holding
  r_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  ar_block_a: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("address taken early");
  err_zero_a: assert property (
    s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0000_0000)
    else $error("error read carries data");
  // Program cycle is a lone pulse
  tick_gap_a: assert property (
    cycle_tick_o |=> !cycle_tick_o [*3]) else $error("tick too dense");
endmodule

bind ssl_top ssl_top_props #(.N_CHAN(N_CHAN), .TICK_CYC(TICK_CYC)) u_props (.*);

// >>> testbench/ssl_top_tb.sv
// Self-checking bench for the thirty-two channel smoothing filter
`timescale 1ns/1ps
`include "ssl_map.svh"

module ssl_top_tb;
  logic        sys_clk_i, reset_n_i, cycle_tick_o;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          num_errors, num_checks, seed, ch, t0, w, p, n, k;
  int          cyc = 0;
  int          tick_cnt = 0;
  logic [15:0] raw, g, tg;

  ssl_top #(.N_CHAN(32), .TICK_CYC(4)) DUT (.*);
  ssl_axi_master u_bus (.*);

  // Clock of 25 ns
  initial begin
    sys_clk_i = 1'h0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  // Tick count and run limit
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cycle_tick_o) tick_cnt <= tick_cnt + 1;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end

  // Saturated input times gain
  function automatic logic [15:0] scl(input logic [15:0] x,
                                      input logic [15:0] k);
    longint p;
    p = longint'($signed(x)) * longint'(k) / longint'(`SSL_GAIN_ONE);
    if (p > `SSL_OUT_MAX) p = `SSL_OUT_MAX;
    if (p < `SSL_OUT_MIN) p = `SSL_OUT_MIN;
    return p[15:0];
  endfunction

  // Output after n steps toward tgt from zero
  function automatic logic [15:0] stp(input int n, input int k,
                                      input int tgt);
    int y;
    y = 0;
    for (int i = 0; i < n; i++) y = y + (tgt - y) / k;
    return y[15:0];
  endfunction

  function automatic logic [11:0] ca(input int n, input logic [3:0] o);
    return `SSL_CHAN_BASE + `SSL_CHAN_STRIDE * n[11:0] + {8'h00, o};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrc(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    logic [1:0] r;
    u_bus.wr(a, d, r);
    chk({30'h0000_0000, r}, {30'h0000_0000, er});
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                     input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    u_bus.rd(a, d, r);
    chk(d, e);
    chk({30'h0000_0000, r}, {30'h0000_0000, er});
  endtask

  // Compare the low half of a channel output
  task automatic rdo(input int n, input logic [15:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    u_bus.rd(ca(n, `SSL_CH_OUT_OFFS), d, r);
    chk({16'h0000, d[15:0]}, {16'h0000, e});
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    seed = 32'h0000_4EE9;
    num_errors = 0;
    num_checks = 0;
    reset_n_i = 1'h0;
    repeat (8) @(posedge sys_clk_i);
    reset_n_i <= 1'h1;
    rdc(`SSL_CTRL_OFFS, 32'h0000_0000, 2'h0);
    rdc(`SSL_TICK_OFFS, 32'h0000_0001, 2'h0);
    rdc(ca(0, `SSL_CH_TG_OFFS), 32'h0064_0000, 2'h0);
    rdc(ca(31, `SSL_CH_OUT_OFFS), 32'h0000_0000, 2'h0);
    rdc(12'h0F0, 32'h0000_0000, 2'h2);
    wrc(ca(3, `SSL_CH_OUT_OFFS), 32'h0000_1234, 2'h2);
    wrc(`SSL_TICK_OFFS, 32'h0000_0000, 2'h0);
    rdc(`SSL_TICK_OFFS, 32'h0000_0001, 2'h0);
    wrc(`SSL_TICK_OFFS, 32'h0000_0002, 2'h0);
    rdc(`SSL_TICK_OFFS, 32'h0000_0002, 2'h0);
    $display("test registers done");
    // Bypass with corner and random gains
    wrc(`SSL_CTRL_OFFS, 32'h0000_0001, 2'h0);
    for (int i = 0; i < 8; i++) begin
      ch  = $random(seed) & 31;
      raw = (i < 2) ? ((i == 0) ? 16'h7FFF : 16'h8000) : 16'($random(seed));
      g   = (i < 2) ? 16'hFFFF : (i == 2) ? 16'h0000
          : (i == 3) ? `SSL_GAIN_ONE : 16'($random(seed));
      wrc(ca(ch, `SSL_CH_RAW_OFFS), {16'h0000, raw}, 2'h0);
      wrc(ca(ch, `SSL_CH_TG_OFFS), {g, 16'h0000}, 2'h0);
      wrc(ca(ch, `SSL_CH_ENA_OFFS), 32'h0000_0001, 2'h0);
      t0 = tick_cnt;
      wait (tick_cnt >= t0 + 2);
      rdo(ch, scl(raw, g));
      wrc(ca(ch, `SSL_CH_ENA_OFFS), 32'h0000_0000, 2'h0);
      rdo(ch, 16'h0000);
    end
    $display("test bypass done");
    // Step response on channel 5, stopping the cycle to count steps
    for (int j = 0; j < 3; j++) begin
      tg = (j == 0) ? 16'h0003 : (j == 1) ? `SSL_FAST_TG_MAX : 16'h0014;
      wrc(`SSL_CTRL_OFFS, 32'h0000_0000, 2'h0);
      wrc(ca(5, `SSL_CH_RAW_OFFS), 32'h0000_0000, 2'h0);
      wrc(ca(5, `SSL_CH_TG_OFFS), {`SSL_GAIN_ONE, tg}, 2'h0);
      wrc(ca(5, `SSL_CH_ENA_OFFS), 32'h0000_0001, 2'h0);
      wrc(`SSL_CTRL_OFFS, 32'h0000_0001, 2'h0);
      t0 = tick_cnt;
      wait (tick_cnt >= t0 + 3);
      wrc(`SSL_CTRL_OFFS, 32'h0000_0000, 2'h0);
      repeat (8) @(posedge sys_clk_i);
      w = tick_cnt - t0 - 1;
      wrc(ca(5, `SSL_CH_RAW_OFFS), 32'h0000_2EE0, 2'h0);
      wrc(`SSL_STAT_OFFS, 32'h0000_0000, 2'h0);
      t0 = tick_cnt;
      wrc(`SSL_CTRL_OFFS, 32'h0000_0001, 2'h0);
      wait (tick_cnt >= t0 + 110);
      wrc(`SSL_CTRL_OFFS, 32'h0000_0000, 2'h0);
      repeat (8) @(posedge sys_clk_i);
      // Program cycles per step and steps per recovery time
      p = (tg <= `SSL_FAST_TG_MAX) ? 1 : int'(tg) / 10;
      k = (tg <= `SSL_FAST_TG_MAX) ? int'(tg) * 10 : 100;
      n = (w + tick_cnt - t0) / p - w / p;
      rdo(5, stp(n, k, 12000));
      rdc(`SSL_STAT_OFFS, n, 2'h0);
      wrc(ca(5, `SSL_CH_ENA_OFFS), 32'h0000_0000, 2'h0);
      rdo(5, 16'h0000);
    end
    $display("test step done");
    test_done();
  end
endmodule

// >>> verilog/ssl_chan.sv
// One smoothing filter channel: step arithmetic and its own period counter
`timescale 1ns/1ps
`include "ssl_map.svh"

module ssl_chan (
  // Clock and reset
  input  wire logic               sys_clk_i,
  input  wire logic               reset_n_i,
  // Program cycle tick
  input  wire logic               cycle_tick_i,
  // Channel controls
  input  wire logic               filter_enable_coil_i,
  input  wire ssl_pkg::ssl_sample_t raw_input_value_i,
  input  wire logic [15:0]        recovery_time_i,
  input  wire logic [15:0]        gain_percent_i,
  // Result
  output logic signed [15:0]      filtered_output_o,
  output logic                    step_o
);

  ssl_pkg::ssl_state_t state_q, state_d;
  logic signed [15:0] out_q, out_d;
  logic [15:0]        cnt_q, cnt_d;

  // ****************************************
  // Scaled input and step arithmetic
  // ****************************************
  // Gain in percent, divided by one hundred
  wire signed [33:0] prod_w   = raw_input_value_i *
                                $signed({1'b0, gain_percent_i});
  wire signed [33:0] scaled_w = prod_w / 34'sd100;
  // Scan interval in 10 ms units: 1 up to 1 s, else Tg/10
  wire [15:0]        per_w    = (recovery_time_i <= `SSL_FAST_TG_MAX) ?
                                16'h0001 : (recovery_time_i / 16'd10);
  // Steps in one recovery time: Tg*10 up to 1 s, else 100
  wire [15:0]        tg_ticks_w = (recovery_time_i <= `SSL_FAST_TG_MAX) ?
                                  (recovery_time_i * 16'd10) : 16'd100;
  wire signed [35:0] diff_w   = {{2{scaled_w[33]}}, scaled_w} -
                                36'(out_q);
  wire signed [35:0] upd_w    = (tg_ticks_w == 16'h0000) ? diff_w :
                                diff_w / $signed({20'h0_0000, tg_ticks_w});
  wire signed [35:0] sum_w    = 36'(out_q) + upd_w;
  wire signed [35:0] pass_w   = {{2{scaled_w[33]}}, scaled_w};
  wire signed [35:0] pick_w   = (recovery_time_i == 16'h0000) ? pass_w :
                                sum_w;
  wire signed [15:0] sat_w    =
      (pick_w > 36'sd32767)  ? 16'sh7FFF :
      (pick_w < -36'sd32768) ? -16'sh8000 : pick_w[15:0];
  wire               due_w    = cycle_tick_i && (cnt_q == 16'h0000);

  // ****************************************
  // Next state
  // ****************************************
  // Whole number of program cycles per step
  always_comb begin
    state_d = state_q;
    out_d   = out_q;
    cnt_d   = cnt_q;
    if (!filter_enable_coil_i) begin
      state_d = ssl_pkg::SSL_FIRST;
      out_d   = 16'sh0000;
      cnt_d   = 16'h0000;
    end else begin
      unique case (state_q)
        ssl_pkg::SSL_IDLE,
        ssl_pkg::SSL_FIRST: begin
          if (cycle_tick_i) begin
            out_d   = (scaled_w > 34'sd32767) ? 16'sh7FFF :
                      (scaled_w < -34'sd32768) ? -16'sh8000 :
                      scaled_w[15:0];
            state_d = ssl_pkg::SSL_RUN;
            cnt_d   = per_w - 16'h0001;
          end
        end
        ssl_pkg::SSL_RUN: begin
          if (due_w) begin
            out_d = sat_w;
            cnt_d = per_w - 16'h0001;
          end else if (cycle_tick_i) begin
            cnt_d = cnt_q - 16'h0001;
          end
        end
      endcase
    end
  end

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ssl_pkg::SSL_IDLE;
      out_q   <= 16'sh0000;
      cnt_q   <= 16'h0000;
    end else begin
      state_q <= state_d;
      out_q   <= out_d;
      cnt_q   <= cnt_d;
    end
  end

  assign filtered_output_o = out_q;
  assign step_o = filter_enable_coil_i && (state_q == ssl_pkg::SSL_RUN) &&
                  due_w;

endmodule

// >>> verilog/ssl_top.sv
// Thirty-two channel signal smoothing filter with an AXI4-Lite register slave
// How it works
// - enable coil high runs the filter; low holds it inactive.
// - inactive enable clears all filter state and forces output to zero.
// - raw input is a signed 16-bit value.
// - filtered output is a signed 16-bit value.
// - recovery time is unsigned 16-bit, in 100 ms units.
// - gain is an unsigned percent; 100 means a factor of one.
// - input is multiplied by the gain before smoothing.
// - first step after start or reset loads output with the input.
// - update is scan interval over recovery time times scaled difference.
// - scan interval 10 ms up to 1 s, else recovery time over 100.
// - scan interval is a whole number of program cycles.
// - output refreshes each time its update interval expires.
// - step response is exponential, 0.63 after one recovery time.
// - thirty-two independent channels, each with own controls and output.
`timescale 1ns/1ps
`include "ssl_map.svh"

module ssl_top #(
  parameter int unsigned N_CHAN    = 32,
  parameter int unsigned TICK_CYC  = `SSL_BASE_TICK_CYC
) (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  // AXI4-Lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Program cycle marker
  output logic             cycle_tick_o
);

  // ****************************************
  // Register storage
  // ****************************************
  logic                     run_q;
  logic [15:0]              cyc_div_q;
  logic [N_CHAN-1:0]        ena_q;
  ssl_pkg::ssl_sample_t     raw_q  [N_CHAN];
  logic [15:0]              tg_q   [N_CHAN];
  logic [15:0]              gain_q [N_CHAN];
  logic signed [15:0]       out_w  [N_CHAN];
  logic [N_CHAN-1:0]        step_w;
  logic [31:0]              step_cnt_q;

  // ****************************************
  // Program cycle generator
  // ****************************************
  logic [31:0] base_q;
  logic [15:0] div_cnt_q;
  logic        cycle_tick_q;
  wire         base_hit_w = (base_q == TICK_CYC - 1);
  wire         div_hit_w  = base_hit_w && (div_cnt_q == 16'h0000);

  // Base 10 ms tick divided into program cycles
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      base_q       <= 32'h0000_0000;
      div_cnt_q    <= 16'h0000;
      cycle_tick_q <= 1'b0;
    end else begin
      base_q       <= (base_hit_w || !run_q) ? 32'h0000_0000 :
                      base_q + 32'h0000_0001;
      cycle_tick_q <= run_q && div_hit_w;
      if (base_hit_w)
        div_cnt_q <= (div_cnt_q == 16'h0000) ?
                     (cyc_div_q - 16'h0001) : (div_cnt_q - 16'h0001);
    end
  end

  assign cycle_tick_o = cycle_tick_q;

  // ****************************************
  // Filter channels
  // ****************************************
  // One independent instance per channel
  for (genvar g = 0; g < N_CHAN; g++) begin : g_chan
    ssl_chan u_chan (
      .sys_clk_i            (sys_clk_i),
      .reset_n_i            (reset_n_i),
      .cycle_tick_i         (cycle_tick_q),
      .filter_enable_coil_i (ena_q[g]),
      .raw_input_value_i    (raw_q[g]),
      .recovery_time_i      (tg_q[g]),
      .gain_percent_i       (gain_q[g]),
      .filtered_output_o    (out_w[g]),
      .step_o               (step_w[g])
    );
  end

  // ****************************************
  // Write channel
  // ****************************************
  logic [11:0] awaddr_q;
  logic        aw_held_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        w_held_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;

  wire         do_wr_w   = aw_held_q && w_held_q && !bvalid_q;
  wire         wr_glob_w = (awaddr_q < `SSL_CHAN_BASE);
  wire [11:0]  wr_rel_w  = awaddr_q - `SSL_CHAN_BASE;
  wire [7:0]   wr_ch_w   = wr_rel_w[11:4];
  wire [3:0]   wr_fld_w  = wr_rel_w[3:0];
  wire         wr_ok_w   = wr_glob_w ?
                           (awaddr_q == `SSL_CTRL_OFFS ||
                            awaddr_q == `SSL_TICK_OFFS ||
                            awaddr_q == `SSL_STAT_OFFS) :
                           (wr_ch_w < N_CHAN && wr_fld_w != `SSL_CH_OUT_OFFS);

  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready  = !w_held_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // Capture address and data in either order, answer after both
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      awaddr_q  <= 12'h000;
      aw_held_q <= 1'b0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      w_held_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'b00;
    end else begin
      if (s_axi_awvalid && !aw_held_q) begin
        awaddr_q  <= {s_axi_awaddr[11:2], 2'b00};
        aw_held_q <= 1'b1;
      end
      if (s_axi_wvalid && !w_held_q) begin
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        w_held_q <= 1'b1;
      end
      if (do_wr_w) begin
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_ok_w ? 2'b00 : 2'b10;
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Byte-lane masked values for the 16-bit fields, unstrobed bytes zero
  wire [15:0] wr_lo_w = {wstrb_q[1] ? wdata_q[15:8] : 8'h00,
                         wstrb_q[0] ? wdata_q[7:0]  : 8'h00};
  wire [15:0] wr_hi_w = {wstrb_q[3] ? wdata_q[31:24] : 8'h00,
                         wstrb_q[2] ? wdata_q[23:16] : 8'h00};

  // Register updates from software and the step counter
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run_q      <= 1'b0;
      cyc_div_q  <= `SSL_TICK_RST;
      ena_q      <= '0;
      step_cnt_q <= 32'h0000_0000;
      for (int i = 0; i < N_CHAN; i++) begin
        raw_q[i]  <= 16'sh0000;
        tg_q[i]   <= 16'h0000;
        gain_q[i] <= `SSL_GAIN_ONE;
      end
    end else begin
      if (do_wr_w && wr_ok_w && wr_glob_w) begin
        if (awaddr_q == `SSL_CTRL_OFFS && wstrb_q[0])
          run_q <= wdata_q[`SSL_CTRL_RUN_BIT];
        if (awaddr_q == `SSL_TICK_OFFS)
          cyc_div_q <= (wr_lo_w == 16'h0000) ? 16'h0001 : wr_lo_w;
      end
      if (do_wr_w && wr_ok_w && awaddr_q == `SSL_STAT_OFFS)
        step_cnt_q <= {31'h0000_0000, |step_w};  // Step in clear cycle kept
      else if (|step_w)
        step_cnt_q <= step_cnt_q + 32'h0000_0001;
      if (do_wr_w && wr_ok_w && !wr_glob_w) begin
        unique case (wr_fld_w)
          `SSL_CH_ENA_OFFS: if (wstrb_q[0])
            ena_q[wr_ch_w[4:0]] <= wdata_q[0];
          `SSL_CH_RAW_OFFS:
            raw_q[wr_ch_w[4:0]] <= wr_lo_w;
          `SSL_CH_TG_OFFS: begin
            tg_q[wr_ch_w[4:0]]   <= wr_lo_w;
            gain_q[wr_ch_w[4:0]] <= wr_hi_w;
          end
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        rvalid_q;

  wire         rd_glob_w = (s_axi_araddr < `SSL_CHAN_BASE);
  wire [11:0]  rd_addr_w = {s_axi_araddr[11:2], 2'b00};
  wire [11:0]  rd_rel_w  = rd_addr_w - `SSL_CHAN_BASE;
  wire [4:0]   rd_ch_w   = rd_rel_w[8:4];
  wire [3:0]   rd_fld_w  = rd_rel_w[3:0];
  wire         rd_chok_w = !rd_glob_w && (rd_rel_w[11:4] < N_CHAN);
  wire [31:0]  rd_ch_data_w =
      (rd_fld_w == `SSL_CH_ENA_OFFS) ? {31'h0, ena_q[rd_ch_w]} :
      (rd_fld_w == `SSL_CH_RAW_OFFS) ? {16'h0000, raw_q[rd_ch_w]} :
      (rd_fld_w == `SSL_CH_TG_OFFS)  ? {gain_q[rd_ch_w], tg_q[rd_ch_w]} :
                                       {16'h0000, out_w[rd_ch_w]};
  wire         rd_ok_w   = rd_glob_w ?
                           (rd_addr_w == `SSL_CTRL_OFFS ||
                            rd_addr_w == `SSL_TICK_OFFS ||
                            rd_addr_w == `SSL_STAT_OFFS) : rd_chok_w;
  wire [31:0]  rd_data_w =
      !rd_ok_w                      ? 32'h0000_0000 :
      (rd_addr_w == `SSL_CTRL_OFFS) ? {31'h0, run_q} :
      (rd_addr_w == `SSL_TICK_OFFS) ? {16'h0000, cyc_div_q} :
      (rd_addr_w == `SSL_STAT_OFFS) ? step_cnt_q : rd_ch_data_w;

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // One-cycle read answer, held until taken
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= 2'b00;
      rvalid_q <= 1'b0;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rdata_q  <= rd_data_w;
      rresp_q  <= rd_ok_w ? 2'b00 : 2'b10;
      rvalid_q <= 1'b1;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule
